// *** inc/wdt_cfg.svh ***
// constants of the system watchdog control block: offsets, reset values, timing
// assumes a 20 MHz system clock; included by its bare name
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register indices; byte address is four times the index
`define IDX_CFG_TWO 10'h091
`define IDX_CFG_THREE 10'h092
`define IDX_IRQ_STATUS 10'h098
`define IDX_IRQ_MASK 10'h099
`define IDX_WDT_STATE 10'h09a

// reset values
`define CFG_TWO_RST 8'h03
`define CFG_THREE_RST 8'h00
`define IRQ_STATUS_RST 8'h00
`define IRQ_MASK_RST 8'h00

// field positions
`define CLR_STROBE_BIT 0
`define SEQ_BITS_HI 4
`define SEQ_BITS_LO 1
`define EVT_EXPIRY_BIT 0
`define EVT_REFUSED_BIT 1

// timing
`define CLK_PERIOD_NS 50
`define TICK_PERIOD_NS 1000000
`define MS_PER_S 1000
`define WDT_T00_S 2
`define WDT_T01_S 16
`define WDT_T10_S 64
`define WDT_T11_S 128

`endif

// *** inc/wdt_pkg.sv ***
// types shared by the system watchdog control block
// assumes nothing beyond a SystemVerilog compiler
package wdt_pkg;

  typedef enum logic [1:0] {
    TWD_2S,
    TWD_16S,
    TWD_64S,
    TWD_128S
  } timeout_select_t;

  // low five bits of the second global configuration register
  typedef struct packed {
    logic global_low_power_request;
    logic sleep_auto_clear;
    logic watchdog_enable_bit;
    timeout_select_t timeout_select;
  } cfg_two_t;

  // interrupt status and mask layout
  typedef struct packed {
    logic refused_write;
    logic expiry;
  } wdt_events_t;

  // latched ahb address phase
  typedef struct packed {
    logic [9:0] index;
    logic mapped_high;
    logic write;
  } ahb_addr_t;

  typedef enum {
    WD_IDLE,
    WD_RUN
  } wd_state_t;

  typedef enum {
    BUS_IDLE,
    BUS_WDATA,
    BUS_RWAIT,
    BUS_RDATA
  } bus_state_t;

endpackage

// *** rtl/system_watchdog_control.sv ***
// system watchdog control: enable, period, clear, sleep auto-clear, fused locks,
// global low-power request, ahb-lite register slave and one level interrupt
// assumes fuse straps, sleep state and global shutdown are synchronous levels
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module system_watchdog_control
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int PERIOD_00_TICKS = `WDT_T00_S * `MS_PER_S,
  parameter int PERIOD_01_TICKS = `WDT_T01_S * `MS_PER_S,
  parameter int PERIOD_10_TICKS = `WDT_T10_S * `MS_PER_S,
  parameter int PERIOD_11_TICKS = `WDT_T11_S * `MS_PER_S
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_FUSED_ENABLE_LOCK,
  input wire logic I_FUSED_PERIOD_LOCK,
  input wire logic I_SLEEP_STATE,
  input wire logic I_GLOBAL_SHUTDOWN,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  output logic O_GLOBAL_LOW_POWER,
  output logic O_WDT_EXPIRY,
  output logic O_WDT_RUNNING,
  output logic O_IRQ
);

  // ---------------- bus slave ----------------
  bus_state_t bus_reg;
  bus_state_t bus_next;
  ahb_addr_t addr_reg;
  ahb_addr_t addr_next;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  wire accept = I_HSEL & I_HREADY & I_HTRANS[1];
  wire accept_read = accept & ~I_HWRITE;
  wire wr_commit = (bus_reg == BUS_WDATA) & addr_reg.write & addr_reg.mapped_high;
  wire rd_capture = (bus_reg == BUS_RWAIT);
  wire [7:0] wbyte = I_HWDATA[7:0];

  wire ahb_addr_t addr_in = '{index: I_HADDR[11:2], mapped_high: (I_HADDR[31:12] == 20'h00000),
                              write: I_HWRITE};
  assign addr_next = accept ? addr_in : addr_reg;

  always_comb
  begin
    bus_next = BUS_IDLE;
    case (bus_reg)
      BUS_IDLE, BUS_WDATA, BUS_RDATA:
      begin
        if (accept)
          bus_next = I_HWRITE ? BUS_WDATA : BUS_RWAIT;
        else
          bus_next = BUS_IDLE;
      end
      BUS_RWAIT: bus_next = BUS_RDATA;
      default: bus_next = BUS_IDLE;
    endcase
  end

  // reads take one wait state so a write just before is visible
  assign hreadyout_next = (bus_reg == BUS_RWAIT) ? 1'b1 : ~accept_read;

  wire sel_two = addr_reg.index == `IDX_CFG_TWO;
  wire sel_three = addr_reg.index == `IDX_CFG_THREE;
  wire sel_status = addr_reg.index == `IDX_IRQ_STATUS;
  wire sel_mask = addr_reg.index == `IDX_IRQ_MASK;
  wire sel_state = addr_reg.index == `IDX_WDT_STATE;

  wire wr_two = wr_commit & sel_two;
  wire wr_three = wr_commit & sel_three;
  wire wr_mask = wr_commit & sel_mask;
  wire rd_status = rd_capture & addr_reg.mapped_high & sel_status;

  // ---------------- configuration ----------------
  cfg_two_t cfg_reg;
  cfg_two_t cfg_next;
  logic [3:0] seq_reg;
  logic [3:0] seq_next;
  wdt_events_t mask_reg;
  wdt_events_t mask_next;

  wire cfg_two_t wr_cfg = wbyte[4:0];
  wire en_lock_hit = I_FUSED_ENABLE_LOCK & cfg_reg.watchdog_enable_bit;
  wire period_locked = I_FUSED_PERIOD_LOCK & cfg_reg.watchdog_enable_bit;

  wire en_written = en_lock_hit ? 1'b1 : wr_cfg.watchdog_enable_bit;
  wire en_next = I_GLOBAL_SHUTDOWN ? 1'b0 :
    (wr_two ? en_written : cfg_reg.watchdog_enable_bit);

  wire timeout_select_t twd_next = (wr_two & ~period_locked) ?
    wr_cfg.timeout_select : cfg_reg.timeout_select;

  assign cfg_next.global_low_power_request = wr_two ? wr_cfg.global_low_power_request :
    cfg_reg.global_low_power_request;
  assign cfg_next.sleep_auto_clear = wr_two ? wr_cfg.sleep_auto_clear :
    cfg_reg.sleep_auto_clear;
  assign cfg_next.watchdog_enable_bit = en_next;
  assign cfg_next.timeout_select = twd_next;

  // sequencer bits of the third register are storage only here
  assign seq_next = wr_three ? wbyte[`SEQ_BITS_HI:`SEQ_BITS_LO] : seq_reg;
  assign mask_next = wr_mask ? wdt_events_t'(wbyte[1:0]) : mask_reg;

  // clear strobe is a pulse, never stored
  wire clr_strobe = wr_three & wbyte[`CLR_STROBE_BIT];

  wire refused = wr_two & ((en_lock_hit & ~wr_cfg.watchdog_enable_bit) |
    (period_locked & (wr_cfg.timeout_select != cfg_reg.timeout_select)));

  // ---------------- watchdog timer ----------------
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int CNT_W = $clog2(PERIOD_11_TICKS + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  wd_state_t wd_reg;
  wd_state_t wd_next;
  logic [TICK_W-1:0] div_reg;
  logic [TICK_W-1:0] div_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] period_last;
  logic expiry_next;

  always_comb
  begin
    case (cfg_reg.timeout_select)
      TWD_2S: period_last = CNT_W'(PERIOD_00_TICKS - 1);
      TWD_16S: period_last = CNT_W'(PERIOD_01_TICKS - 1);
      TWD_64S: period_last = CNT_W'(PERIOD_10_TICKS - 1);
      TWD_128S: period_last = CNT_W'(PERIOD_11_TICKS - 1);
      default: period_last = CNT_W'(PERIOD_11_TICKS - 1);
    endcase
  end

  always_comb
  begin
    wd_next = WD_IDLE;
    case (wd_reg)
      WD_IDLE: wd_next = (cfg_reg.watchdog_enable_bit & ~I_GLOBAL_SHUTDOWN) ? WD_RUN : WD_IDLE;
      WD_RUN: wd_next = (cfg_reg.watchdog_enable_bit & ~I_GLOBAL_SHUTDOWN) ? WD_RUN : WD_IDLE;
      default: wd_next = WD_IDLE;
    endcase
  end

  wire sleep_clear = I_SLEEP_STATE & cfg_reg.sleep_auto_clear;
  wire hold_zero = (wd_reg != WD_RUN) | I_GLOBAL_SHUTDOWN | clr_strobe | sleep_clear;
  wire tick = div_reg == TICK_LAST;
  wire at_period = cnt_reg == period_last;

  assign div_next = (hold_zero | tick) ? '0 : div_reg + TICK_W'(1);
  assign expiry_next = ~hold_zero & tick & at_period;

  always_comb
  begin
    if (hold_zero)
      cnt_next = '0;
    else if (tick)
      cnt_next = at_period ? '0 : cnt_reg + CNT_W'(1);
    else
      cnt_next = cnt_reg;
  end

  // ---------------- interrupts ----------------
  wdt_events_t status_reg;
  wdt_events_t status_next;
  wdt_events_t status_set;

  assign status_set.expiry = expiry_next;
  assign status_set.refused_write = refused;
  // a new event in the read-clear cycle survives
  assign status_next = (rd_status ? '0 : status_reg) | status_set;
  wire irq_next = |(status_next & mask_next);

  // ---------------- read mux ----------------
  logic [7:0] rbyte;

  always_comb
  begin
    rbyte = 8'h00;
    if (addr_reg.mapped_high)
    begin
      if (sel_two)
        rbyte = {3'h0, cfg_reg};
      else if (sel_three)
        rbyte = {3'h0, seq_reg, 1'b0};
      else if (sel_status)
        rbyte = {6'h00, status_reg};
      else if (sel_mask)
        rbyte = {6'h00, mask_reg};
      else if (sel_state)
        rbyte = {4'h0, I_FUSED_PERIOD_LOCK, I_FUSED_ENABLE_LOCK, sleep_clear, wd_reg == WD_RUN};
      else
        rbyte = 8'h00;
    end
  end

  assign hrdata_next = rd_capture ? {24'h000000, rbyte} : hrdata_reg;

  // ---------------- state ----------------
  // bus slave flops; ready idles high so the first address phase is taken
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      bus_reg <= BUS_IDLE;
    else
      bus_reg <= bus_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      addr_reg <= '0;
    else
      addr_reg <= addr_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      hreadyout_reg <= 1'b1;
    else
      hreadyout_reg <= hreadyout_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      hrdata_reg <= 32'h00000000;
    else
      hrdata_reg <= hrdata_next;
  end

  // register flops; reset words cut to field width on purpose
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      cfg_reg <= cfg_two_t'(5'(`CFG_TWO_RST));
    else
      cfg_reg <= cfg_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      seq_reg <= 4'(`CFG_THREE_RST >> `SEQ_BITS_LO);
    else
      seq_reg <= seq_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      mask_reg <= wdt_events_t'(2'(`IRQ_MASK_RST));
    else
      mask_reg <= mask_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      status_reg <= wdt_events_t'(2'(`IRQ_STATUS_RST));
    else
      status_reg <= status_next;
  end

  // prescaler and count share one reset so no stale tick survives
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      wd_reg <= WD_IDLE;
    else
      wd_reg <= wd_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      div_reg <= '0;
    else
      div_reg <= div_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      O_GLOBAL_LOW_POWER <= 1'b0;
      O_WDT_EXPIRY <= 1'b0;
      O_WDT_RUNNING <= 1'b0;
      O_IRQ <= 1'b0;
      O_HRESP <= 1'b0;
    end
    else
    begin
      O_GLOBAL_LOW_POWER <= cfg_next.global_low_power_request;
      O_WDT_EXPIRY <= expiry_next;
      O_WDT_RUNNING <= wd_next == WD_RUN;
      O_IRQ <= irq_next;
      O_HRESP <= 1'b0;
    end
  end

  assign O_HREADYOUT = hreadyout_reg;
  assign O_HRDATA = hrdata_reg;

endmodule

// *** test/system_watchdog_control_asserts.sv ***
// port checker for the system watchdog control block
// assumes it is bound onto every instance of the block
`timescale 1ns/1ps
module system_watchdog_control_asserts
  import wdt_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_SLEEP_STATE,
  input wire logic I_GLOBAL_SHUTDOWN,
  input wire logic O_HREADYOUT,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HRESP,
  input wire logic O_GLOBAL_LOW_POWER,
  input wire logic O_WDT_EXPIRY,
  input wire logic O_WDT_RUNNING
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  wire taken = I_HSEL && I_HREADY && I_HTRANS[1];
  wire cfg_hit = taken && I_HWRITE && I_HADDR == 32'h0000_0244;
  logic cfg_wr_reg, lp_reg, slp_reg;
  // shadow of the written low-power and sleep-clear bits
  always_ff @(posedge I_SYS_CLK)
  begin
    cfg_wr_reg <= I_RSTN && cfg_hit;
    lp_reg <= !I_RSTN ? 1'b0 : cfg_wr_reg ? I_HWDATA[4] : lp_reg;
    slp_reg <= !I_RSTN ? 1'b0 : cfg_wr_reg ? I_HWDATA[3] : slp_reg;
  end
  sequence rd_answer;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  sequence sleep_held;
    (slp_reg && I_SLEEP_STATE) [*3];
  endsequence
  chk_read_wait: assert property (taken && !I_HWRITE |=> rd_answer)
    else $error("read answer timing wrong");
  chk_write_nowait: assert property (taken && I_HWRITE |=> O_HREADYOUT)
    else $error("write stalled");
  chk_resp_okay: assert property (!O_HRESP)
    else $error("error response seen");
  chk_rdata_upper: assert property (O_HREADYOUT |-> O_HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_low_power: assert property (
    cfg_wr_reg |=> ##[0:1] O_GLOBAL_LOW_POWER == lp_reg)
    else $error("low-power output not following bit");
  chk_sleep_clear: assert property (sleep_held |-> !O_WDT_EXPIRY)
    else $error("expiry while sleep clearing");
  chk_expiry_running: assert property (O_WDT_EXPIRY |-> $past(O_WDT_RUNNING))
    else $error("expiry while not running");
  chk_shutdown_stop: assert property (
    I_GLOBAL_SHUTDOWN |=> ##[0:1] !O_WDT_RUNNING)
    else $error("running after shutdown");
  chk_expiry_gap: assert property (O_WDT_EXPIRY |=> !O_WDT_EXPIRY [*8])
    else $error("expiry not restarting count");
endmodule

bind system_watchdog_control system_watchdog_control_asserts
  system_watchdog_control_asserts_inst (.I_SYS_CLK, .I_RSTN, .I_HSEL, .I_HADDR,
  .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .I_SLEEP_STATE, .I_GLOBAL_SHUTDOWN,
  .O_HREADYOUT, .O_HRDATA, .O_HRESP, .O_GLOBAL_LOW_POWER, .O_WDT_EXPIRY,
  .O_WDT_RUNNING);

// *** test/testbench.sv ***
// self-checking bench for the system watchdog control block
// assumes shortened tick and period parameters to keep the run short
`timescale 1ns/1ps
module testbench;
  import wdt_pkg::*;
  localparam int TICK = 4;
  logic clk = 0, rst_n = 0, hwr = 0, fen = 0, fpl = 0, slp = 0, sd = 0, hsel = 0;
  logic [2:0] hsize = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hready, hresp, lp, expo, run, irq;
  int err_count = 0, check_count = 0, cyc = 0, exp_cnt = 0, n, e;
  system_watchdog_control #(.TICK_CYCLES(TICK), .PERIOD_00_TICKS(3),
    .PERIOD_01_TICKS(5), .PERIOD_10_TICKS(7), .PERIOD_11_TICKS(9))
    system_watchdog_control_inst (.I_SYS_CLK(clk), .I_RSTN(rst_n), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwr), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .I_FUSED_ENABLE_LOCK(fen),
    .I_FUSED_PERIOD_LOCK(fpl), .I_SLEEP_STATE(slp), .I_GLOBAL_SHUTDOWN(sd),
    .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp),
    .O_GLOBAL_LOW_POWER(lp), .O_WDT_EXPIRY(expo), .O_WDT_RUNNING(run), .O_IRQ(irq));
  always #25 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    exp_cnt += (expo === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hsize <= 3'h2;
    haddr <= a;
    hwr <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  task automatic wexp(output int k);
    k = 0;
    do begin @(posedge clk); k++; end while (expo !== 1'b1 && k < 100);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(32'h244, 32'h3);
    rd(32'h248, 32'h0);
    rd(32'h260, 32'h0);
    rd(32'h264, 32'h0);
    rd(32'h300, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      bus(32'h244, 1'b1, i ? 32'h3 : 32'h13);
      repeat (2) @(posedge clk);
      chk(lp, !i);
    end
    for (int s = 0; s < 4; s++)
    begin
      bus(32'h248, 1'b1, 32'h1);
      bus(32'h244, 1'b1, 32'h4 | s);
      wexp(n);
      wexp(n);
      chk(n, (3 + 2 * s) * TICK);
      chk(run, 1'b1);
    end
    rd(32'h260, 32'h1);
    bus(32'h264, 1'b1, 32'h1);
    wexp(n);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rd(32'h260, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    bus(32'h248, 1'b1, 32'h1);
    bus(32'h244, 1'b1, 32'h4);
    e = exp_cnt;
    repeat (8) bus(32'h248, 1'b1, 32'h1);
    chk(exp_cnt, e);
    repeat (6) bus(32'h248, 1'b1, 32'h0);
    chk(exp_cnt > e, 1'b1);
    rd(32'h248, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      bus(32'h244, 1'b1, i ? 32'h4 : 32'hc);
      slp <= 1'b1;
      // let a pulse launched before sleep land first
      repeat (2) @(posedge clk);
      e = exp_cnt;
      repeat (38) @(posedge clk);
      chk(exp_cnt > e, i);
      slp <= 1'b0;
      repeat (20) @(posedge clk);
      chk(exp_cnt > e, 1'b1);
    end
    fen <= 1'b1;
    bus(32'h244, 1'b1, 32'h0);
    rd(32'h244, 32'h4);
    chk(run, 1'b1);
    bus(32'h260, 1'b0, 32'h0);
    chk(q[1], 1'b1);
    fpl <= 1'b1;
    bus(32'h244, 1'b1, 32'h5);
    rd(32'h244, 32'h4);
    @(posedge clk);
    sd <= 1'b1;
    @(posedge clk);
    sd <= 1'b0;
    repeat (3) @(posedge clk);
    chk(run, 1'b0);
    rd(32'h244, 32'h0);
    bus(32'h244, 1'b1, 32'h1);
    rd(32'h244, 32'h1);
    fen <= 1'b0;
    bus(32'h244, 1'b1, 32'h5);
    repeat (2) @(posedge clk);
    chk(run, 1'b1);
    bus(32'h244, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    chk(run, 1'b0);
    rd(32'h268, 32'h8);
    // unselected address phase must not land
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= 32'h244;
    hwr <= 1'b1;
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= 32'h14;
    @(posedge clk);
    rd(32'h244, 32'h1);
    chk(lp, 1'b0);
    report_and_stop();
  end
endmodule
